// *** verilog/lmb_decode_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE_01: AND into main register: bank/indirect 1B/1C, direct/immediate 2B/1C.
// RULE_02: AND into direct byte: from main 2B/1C, from immediate 3B/2C.
// RULE_03: OR into main register: bank/indirect 1B/1C, direct/immediate 2B/1C.
// RULE_04: OR into direct byte: from main 2B/1C, from immediate 3B/2C.
// RULE_05: XOR into main register: bank/indirect 1B/1C, direct/immediate 2B/1C.
// RULE_06: XOR into direct byte: from main 2B/1C, from immediate 3B/2C.
// RULE_07: Nibble flip swaps main register halves, 1B/1C.
// RULE_08: Zero, invert and four rotations of main register, each 1B/1C.
// RULE_09: Copy to main: bank/indirect 1B/1C, direct/immediate 2B/1C.
// RULE_10: Copy to bank: from main 1B/1C, direct 2B/2C, immediate 2B/1C.
// RULE_11: Copy to direct: main 2B/1C, bank/indirect 2B/2C, direct/immediate 3B/2C.
// RULE_12: Copy to indirect: from main 1B/1C, direct 2B/2C, immediate 2B/1C.
// RULE_13: Load 16-bit pointer with constant, 3B/2C.
// RULE_14: Code table read relative to pointer or program counter, 1B/2C.
// RULE_15: External data move either direction, 8 or 16-bit address, 1B/2C.
// RULE_16: Trade bank/indirect 1B/1C, direct 2B/1C; low-digit trade 1B/1C.
// RULE_17: Push and pop of a direct byte, each 2B/2C.
// RULE_18: Carry zero/set/invert 1B/1C, on bit 2B/1C; bit copies 2B/1C, 2B/2C.
// RULE_19: Carry AND/OR with bit or its inverse, result in carry, 2B/2C.
// RULE_20: Branch on carry set or clear, relative, 2B/2C.
// RULE_21: Branch on bit set or clear, relative, 3B/2C.
// RULE_22: Branch when bit set and clear that bit, 3B/2C.
// RULE_23: Relative offset is signed eight-bit, added to program counter.
// RULE_24: Bit operands map only to bytes 20h-2Fh or SFRs ending 0h/8h.
// RULE_25: External access through 8-bit indirect pointer is not supported.
module lmb_decode_top import lmb_pkg::*; (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic req_valid_in,
   input wire lmb_req_t req_in,
   output logic ready_out,
   output logic done_out,
   output lmb_res_t res_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   // Asserts at once, releases two edges late so no flop sees a runt release
   logic [1:0] rst_pipe;
   logic nrst_sync;

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign nrst_sync = rst_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // Opcode table

   function automatic lmb_dec_t mk(input lmb_op_t op, input lmb_loc_t dst,
                                   input lmb_loc_t src, input logic [1:0] len,
                                   input logic [1:0] cyc);
      lmb_dec_t d;
      d.op = op;
      d.dst = dst;
      d.src = src;
      d.len = len;
      d.cyc = cyc;
      d.illegal = 1'b0;
      return d;
   endfunction

   function automatic lmb_dec_t decode(input logic [7:0] oc);
      lmb_dec_t d;
      d = mk(OP_NONE, LOC_NONE, LOC_NONE, LEN1, CYC1);
      d.illegal = 1'b1;
      case (oc) inside
         // Logical group
         [8'h58:8'h5f]: d = mk(OP_AND, LOC_MAIN, LOC_BANK, LEN1, CYC1); // RULE_01
         8'h55: d = mk(OP_AND, LOC_MAIN, LOC_DIR, LEN2, CYC1); // RULE_01
         [8'h56:8'h57]: d = mk(OP_AND, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_01
         8'h54: d = mk(OP_AND, LOC_MAIN, LOC_IMM, LEN2, CYC1); // RULE_01
         8'h52: d = mk(OP_AND, LOC_DIR, LOC_MAIN, LEN2, CYC1); // RULE_02
         8'h53: d = mk(OP_AND, LOC_DIR, LOC_IMM, LEN3, CYC2); // RULE_02
         [8'h48:8'h4f]: d = mk(OP_OR, LOC_MAIN, LOC_BANK, LEN1, CYC1); // RULE_03
         8'h45: d = mk(OP_OR, LOC_MAIN, LOC_DIR, LEN2, CYC1); // RULE_03
         [8'h46:8'h47]: d = mk(OP_OR, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_03
         8'h44: d = mk(OP_OR, LOC_MAIN, LOC_IMM, LEN2, CYC1); // RULE_03
         8'h42: d = mk(OP_OR, LOC_DIR, LOC_MAIN, LEN2, CYC1); // RULE_04
         8'h43: d = mk(OP_OR, LOC_DIR, LOC_IMM, LEN3, CYC2); // RULE_04
         [8'h68:8'h6f]: d = mk(OP_XOR, LOC_MAIN, LOC_BANK, LEN1, CYC1); // RULE_05
         8'h65: d = mk(OP_XOR, LOC_MAIN, LOC_DIR, LEN2, CYC1); // RULE_05
         [8'h66:8'h67]: d = mk(OP_XOR, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_05
         8'h64: d = mk(OP_XOR, LOC_MAIN, LOC_IMM, LEN2, CYC1); // RULE_05
         8'h62: d = mk(OP_XOR, LOC_DIR, LOC_MAIN, LEN2, CYC1); // RULE_06
         8'h63: d = mk(OP_XOR, LOC_DIR, LOC_IMM, LEN3, CYC2); // RULE_06
         8'hc4: d = mk(OP_NIBFLIP, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_07
         8'he4: d = mk(OP_ZERO, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08
         8'hf4: d = mk(OP_INV, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08
         8'h23: d = mk(OP_ROTL, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08
         8'h33: d = mk(OP_ROTLC, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08
         8'h03: d = mk(OP_ROTR, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08
         8'h13: d = mk(OP_ROTRC, LOC_MAIN, LOC_MAIN, LEN1, CYC1); // RULE_08

         // Data transfer group
         [8'he8:8'hef]: d = mk(OP_COPY, LOC_MAIN, LOC_BANK, LEN1, CYC1); // RULE_09
         8'he5: d = mk(OP_COPY, LOC_MAIN, LOC_DIR, LEN2, CYC1); // RULE_09
         [8'he6:8'he7]: d = mk(OP_COPY, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_09
         8'h74: d = mk(OP_COPY, LOC_MAIN, LOC_IMM, LEN2, CYC1); // RULE_09
         [8'hf8:8'hff]: d = mk(OP_COPY, LOC_BANK, LOC_MAIN, LEN1, CYC1); // RULE_10
         [8'ha8:8'haf]: d = mk(OP_COPY, LOC_BANK, LOC_DIR, LEN2, CYC2); // RULE_10
         [8'h78:8'h7f]: d = mk(OP_COPY, LOC_BANK, LOC_IMM, LEN2, CYC1); // RULE_10
         8'hf5: d = mk(OP_COPY, LOC_DIR, LOC_MAIN, LEN2, CYC1); // RULE_11
         [8'h88:8'h8f]: d = mk(OP_COPY, LOC_DIR, LOC_BANK, LEN2, CYC2); // RULE_11
         8'h85: d = mk(OP_COPY, LOC_DIR, LOC_DIR, LEN3, CYC2); // RULE_11
         [8'h86:8'h87]: d = mk(OP_COPY, LOC_DIR, LOC_IND, LEN2, CYC2); // RULE_11
         8'h75: d = mk(OP_COPY, LOC_DIR, LOC_IMM, LEN3, CYC2); // RULE_11
         [8'hf6:8'hf7]: d = mk(OP_COPY, LOC_IND, LOC_MAIN, LEN1, CYC1); // RULE_12
         [8'ha6:8'ha7]: d = mk(OP_COPY, LOC_IND, LOC_DIR, LEN2, CYC2); // RULE_12
         [8'h76:8'h77]: d = mk(OP_COPY, LOC_IND, LOC_IMM, LEN2, CYC1); // RULE_12
         8'h90: d = mk(OP_DPLOAD, LOC_DP16, LOC_IMM, LEN3, CYC2); // RULE_13
         8'h93: d = mk(OP_CODERD, LOC_MAIN, LOC_CODE_DP, LEN1, CYC2); // RULE_14
         8'h83: d = mk(OP_CODERD, LOC_MAIN, LOC_CODE_PC, LEN1, CYC2); // RULE_14
         [8'he2:8'he3]: d = mk(OP_XMOVE, LOC_MAIN, LOC_XIND, LEN1, CYC2); // RULE_15
         8'he0: d = mk(OP_XMOVE, LOC_MAIN, LOC_XD16, LEN1, CYC2); // RULE_15
         [8'hf2:8'hf3]: d = mk(OP_XMOVE, LOC_XIND, LOC_MAIN, LEN1, CYC2); // RULE_15
         8'hf0: d = mk(OP_XMOVE, LOC_XD16, LOC_MAIN, LEN1, CYC2); // RULE_15
         [8'hc8:8'hcf]: d = mk(OP_TRADE, LOC_MAIN, LOC_BANK, LEN1, CYC1); // RULE_16
         8'hc5: d = mk(OP_TRADE, LOC_MAIN, LOC_DIR, LEN2, CYC1); // RULE_16
         [8'hc6:8'hc7]: d = mk(OP_TRADE, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_16
         [8'hd6:8'hd7]: d = mk(OP_TRADE_LOW, LOC_MAIN, LOC_IND, LEN1, CYC1); // RULE_16
         8'hc0: d = mk(OP_PUSH, LOC_STACK, LOC_DIR, LEN2, CYC2); // RULE_17
         8'hd0: d = mk(OP_POP, LOC_DIR, LOC_STACK, LEN2, CYC2); // RULE_17

         // Boolean group
         8'hc3: d = mk(OP_ZERO, LOC_CARRY, LOC_CARRY, LEN1, CYC1); // RULE_18
         8'hc2: d = mk(OP_ZERO, LOC_BIT, LOC_BIT, LEN2, CYC1); // RULE_18
         8'hd3: d = mk(OP_BITSET, LOC_CARRY, LOC_CARRY, LEN1, CYC1); // RULE_18
         8'hd2: d = mk(OP_BITSET, LOC_BIT, LOC_BIT, LEN2, CYC1); // RULE_18
         8'hb3: d = mk(OP_INV, LOC_CARRY, LOC_CARRY, LEN1, CYC1); // RULE_18
         8'hb2: d = mk(OP_INV, LOC_BIT, LOC_BIT, LEN2, CYC1); // RULE_18
         8'ha2: d = mk(OP_COPY, LOC_CARRY, LOC_BIT, LEN2, CYC1); // RULE_18
         8'h92: d = mk(OP_COPY, LOC_BIT, LOC_CARRY, LEN2, CYC2); // RULE_18
         8'h82: d = mk(OP_CAND, LOC_CARRY, LOC_BIT, LEN2, CYC2); // RULE_19
         8'hb0: d = mk(OP_CANDN, LOC_CARRY, LOC_BIT, LEN2, CYC2); // RULE_19
         8'h72: d = mk(OP_COR, LOC_CARRY, LOC_BIT, LEN2, CYC2); // RULE_19
         8'ha0: d = mk(OP_CORN, LOC_CARRY, LOC_BIT, LEN2, CYC2); // RULE_19
         8'h40: d = mk(OP_BRC, LOC_NONE, LOC_CARRY, LEN2, CYC2); // RULE_20
         8'h50: d = mk(OP_BRNC, LOC_NONE, LOC_CARRY, LEN2, CYC2); // RULE_20
         8'h20: d = mk(OP_BRB, LOC_NONE, LOC_BIT, LEN3, CYC2); // RULE_21
         8'h30: d = mk(OP_BRNB, LOC_NONE, LOC_BIT, LEN3, CYC2); // RULE_21
         8'h10: d = mk(OP_BRBC, LOC_BIT, LOC_BIT, LEN3, CYC2); // RULE_22
         default: d.illegal = 1'b1;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Operand steering

   lmb_core_t core;
   lmb_core_t next_core;
   lmb_dec_t dec;
   lmb_res_t fill;
   logic accept;
   logic tick;
   logic quiet;
   logic [7:0] imm;
   logic [7:0] rel;
   logic [7:0] opnd_a;
   logic [7:0] opnd_b;
   logic [7:0] alu_val;
   logic [7:0] alu_aux;
   logic alu_carry;
   logic alu_bit;

   assign ready_out = (core.state == ST_IDLE);
   assign accept = ready_out && req_valid_in;
   assign done_out = (core.state == ST_DONE);
   assign res_out = core.res;

   always_comb begin
      dec = decode(req_in.opcode);
      imm = (dec.len == LEN3) ? req_in.byte2 : req_in.byte1;
      // Bit branches carry the bit address first, offset second
      rel = (dec.len == LEN3) ? req_in.byte2 : req_in.byte1;
      // Direct destinations combine with their own old value
      opnd_a = (dec.dst == LOC_DIR) ? req_in.dst_val : req_in.main_val;
      case (dec.src)
         LOC_MAIN: opnd_b = req_in.main_val;
         LOC_IMM: opnd_b = imm;
         default: opnd_b = req_in.src_val;
      endcase
   end

   lmb_alu lmb_alu_i (
      .op_in(dec.op),
      .a_in(opnd_a),
      .b_in(opnd_b),
      .carry_in(req_in.carry),
      .bit_in(req_in.bit_val),
      .val_out(alu_val),
      .aux_out(alu_aux),
      .carry_out(alu_carry),
      .bit_out(alu_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Machine-cycle divider

   lmb_mc_tick lmb_mc_tick_i (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_sync),
      .clr_in(accept),
      .tick_out(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bit address mapping

   logic [7:0] bit_byte;
   logic [2:0] bit_pos;

   // Upper half of the bit space lands on SFRs whose address ends in 0h or 8h
   always_comb begin
      if (req_in.byte1[BIT_AREA_SEL]) begin
         bit_byte = {req_in.byte1[7:3], 3'h0}; // RULE_24
      end else begin
         bit_byte = BIT_RAM_BASE + {4'h0, req_in.byte1[6:3]}; // RULE_24
      end
      bit_pos = req_in.byte1[2:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Relative branches

   logic [15:0] seq_pc;
   logic [15:0] rel_ext;
   logic br_taken;
   logic [15:0] br_target;

   always_comb begin
      // Address of the following instruction; relative forms count from it
      seq_pc = req_in.pc + {14'h0, dec.len};
      rel_ext = {{8{rel[7]}}, rel}; // RULE_23
      case (dec.op)
         OP_BRC: br_taken = req_in.carry; // RULE_20
         OP_BRNC: br_taken = !req_in.carry; // RULE_20
         OP_BRB: br_taken = req_in.bit_val; // RULE_21
         OP_BRNB: br_taken = !req_in.bit_val; // RULE_21
         OP_BRBC: br_taken = req_in.bit_val; // RULE_22
         default: br_taken = 1'b0;
      endcase
      br_target = seq_pc + rel_ext; // RULE_23
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result assembly

   always_comb begin
      fill = RES_RESET;
      // Unsupported and undefined opcodes still time out, so fetch never hangs
      quiet = dec.illegal || dec.src == LOC_XIND || dec.dst == LOC_XIND;
      fill.op = dec.op;
      fill.dst = dec.dst;
      fill.src = dec.src;
      fill.len = dec.len;
      fill.cyc = dec.cyc;
      fill.val = alu_val;
      fill.aux = alu_aux;
      fill.carry = alu_carry;
      fill.bit_val = alu_bit;
      fill.illegal = dec.illegal;
      fill.unsupported = dec.src == LOC_XIND || dec.dst == LOC_XIND; // RULE_25
      fill.bit_byte = bit_byte; // RULE_24
      fill.bit_pos = bit_pos;

      // Write enables
      fill.main_wr = !quiet && dec.dst == LOC_MAIN; // RULE_25
      fill.mem_wr = !quiet && (dec.dst inside {LOC_BANK, LOC_IND, LOC_DIR, LOC_XD16,
                                                LOC_STACK});
      fill.aux_wr = !quiet && (dec.op inside {OP_TRADE, OP_TRADE_LOW}); // RULE_16
      fill.carry_wr = !quiet && (dec.dst == LOC_CARRY ||
                                 dec.op inside {OP_ROTLC, OP_ROTRC}); // RULE_08
      // Bit is cleared only when the branch fires
      fill.bit_wr = !quiet && dec.dst == LOC_BIT &&
                    (dec.op != OP_BRBC || req_in.bit_val); // RULE_22
      fill.dp_load = dec.op == OP_DPLOAD; // RULE_13
      fill.dp_val = {req_in.byte1, req_in.byte2};
      case (dec.src)
         LOC_CODE_DP: fill.mem_addr = req_in.dp16 + {8'h00, req_in.main_val}; // RULE_14
         LOC_CODE_PC: fill.mem_addr = seq_pc + {8'h00, req_in.main_val}; // RULE_14
         LOC_XD16: fill.mem_addr = req_in.dp16; // RULE_15
         default: fill.mem_addr = (dec.dst == LOC_XD16) ? req_in.dp16 : 16'h0000;
      endcase
      fill.br_taken = br_taken; // RULE_20
      fill.br_target = br_target; // RULE_23
   end

   ////////////////////////////////////////////////////////////////////////////
   // Machine-cycle sequencer

   always_comb begin
      next_core = core;
      unique case (core.state)
         ST_IDLE: begin
            if (accept) begin
               next_core.res = fill;
               next_core.left = dec.cyc;
               next_core.state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // Count down whole machine cycles
            if (tick) begin
               if (core.left == CYC1) begin
                  next_core.state = ST_DONE;
               end else begin
                  next_core.left = core.left - CYC1;
               end
            end
         end
         ST_DONE: begin
            next_core.state = ST_IDLE;
         end
         // A corrupted one-hot code falls back to idle instead of locking up
         default: begin
            next_core.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         core.state <= ST_IDLE;
         core.left <= 2'h0;
         core.res <= RES_RESET;
      end else begin
         core <= next_core;
      end
   end

endmodule

`default_nettype wire

// *** include/lmb_pkg.sv ***
package lmb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: one machine cycle of the core, counted in core clocks
   localparam int CLK_PERIOD_NS = 100;
   localparam int MC_PERIOD_NS = 400;
   localparam int MC_CLKS = MC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] MC_LAST = 2'(MC_CLKS - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Byte lengths and machine-cycle counts
   localparam logic [1:0] LEN1 = 2'h1;
   localparam logic [1:0] LEN2 = 2'h2;
   localparam logic [1:0] LEN3 = 2'h3;
   localparam logic [1:0] CYC1 = 2'h1;
   localparam logic [1:0] CYC2 = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Bit addressing
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam int BIT_AREA_SEL = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Operations, operand locations, states
   typedef enum logic [4:0] {
      OP_NONE, OP_AND, OP_OR, OP_XOR, OP_NIBFLIP, OP_ZERO, OP_INV,
      OP_ROTL, OP_ROTLC, OP_ROTR, OP_ROTRC, OP_COPY, OP_DPLOAD, OP_CODERD,
      OP_XMOVE, OP_TRADE, OP_TRADE_LOW, OP_PUSH, OP_POP, OP_BITSET,
      OP_CAND, OP_CANDN, OP_COR, OP_CORN, OP_BRC, OP_BRNC, OP_BRB,
      OP_BRNB, OP_BRBC
   } lmb_op_t;

   typedef enum logic [3:0] {
      LOC_NONE, LOC_MAIN, LOC_BANK, LOC_IND, LOC_DIR, LOC_IMM, LOC_DP16,
      LOC_CODE_DP, LOC_CODE_PC, LOC_XIND, LOC_XD16, LOC_STACK, LOC_CARRY,
      LOC_BIT
   } lmb_loc_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } lmb_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [15:0] pc;
      logic [15:0] dp16;
      logic [7:0] main_val;
      logic [7:0] src_val;
      logic [7:0] dst_val;
      logic carry;
      logic bit_val;
   } lmb_req_t;

   typedef struct packed {
      lmb_op_t op;
      lmb_loc_t dst;
      lmb_loc_t src;
      logic [1:0] len;
      logic [1:0] cyc;
      logic illegal;
   } lmb_dec_t;

   typedef struct packed {
      lmb_op_t op;
      lmb_loc_t dst;
      lmb_loc_t src;
      logic [1:0] len;
      logic [1:0] cyc;
      logic [7:0] val;
      logic [7:0] aux;
      logic carry;
      logic bit_val;
      logic [7:0] bit_byte;
      logic [2:0] bit_pos;
      logic main_wr;
      logic mem_wr;
      logic aux_wr;
      logic carry_wr;
      logic bit_wr;
      logic dp_load;
      logic [15:0] dp_val;
      logic [15:0] mem_addr;
      logic br_taken;
      logic [15:0] br_target;
      logic unsupported;
      logic illegal;
   } lmb_res_t;

   typedef struct packed {
      lmb_state_t state;
      logic [1:0] left;
      lmb_res_t res;
   } lmb_core_t;

   localparam lmb_res_t RES_RESET = '0;

endpackage

// *** verilog/lmb_mc_tick.sv ***
`timescale 1ns/10ps
`default_nettype none

module lmb_mc_tick import lmb_pkg::*; (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic clr_in,
   output logic tick_out
);

   logic [1:0] cnt;
   logic [1:0] next_cnt;

   // Restart on clear so every instruction sees full machine cycles
   always_comb begin
      tick_out = (cnt == MC_LAST) && !clr_in;
      if (clr_in || cnt == MC_LAST) begin
         next_cnt = 2'h0;
      end else begin
         next_cnt = cnt + 2'h1;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 2'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule

`default_nettype wire

// *** verilog/lmb_alu.sv ***
`timescale 1ns/10ps
`default_nettype none

module lmb_alu import lmb_pkg::*; (
   input wire lmb_op_t op_in,
   input wire logic [7:0] a_in,
   input wire logic [7:0] b_in,
   input wire logic carry_in,
   input wire logic bit_in,
   output logic [7:0] val_out,
   output logic [7:0] aux_out,
   output logic carry_out,
   output logic bit_out
);

   always_comb begin
      val_out = a_in;
      aux_out = b_in;
      carry_out = carry_in;
      bit_out = bit_in;
      case (op_in)
         OP_AND: val_out = a_in & b_in; // RULE_01
         OP_OR: val_out = a_in | b_in; // RULE_03
         OP_XOR: val_out = a_in ^ b_in; // RULE_05
         OP_NIBFLIP: val_out = {a_in[3:0], a_in[7:4]}; // RULE_07
         OP_ZERO: begin
            val_out = 8'h00; // RULE_08
            carry_out = 1'b0; // RULE_18
            bit_out = 1'b0;
         end
         OP_INV: begin
            val_out = ~a_in; // RULE_08
            carry_out = ~carry_in; // RULE_18
            bit_out = ~bit_in;
         end
         OP_BITSET: begin
            carry_out = 1'b1; // RULE_18
            bit_out = 1'b1;
         end
         OP_ROTL: val_out = {a_in[6:0], a_in[7]}; // RULE_08
         OP_ROTR: val_out = {a_in[0], a_in[7:1]}; // RULE_08
         OP_ROTLC: begin
            val_out = {a_in[6:0], carry_in}; // RULE_08
            carry_out = a_in[7];
         end
         OP_ROTRC: begin
            val_out = {carry_in, a_in[7:1]}; // RULE_08
            carry_out = a_in[0];
         end
         OP_COPY, OP_CODERD, OP_XMOVE, OP_PUSH, OP_POP: begin
            val_out = b_in; // RULE_09
            carry_out = bit_in; // RULE_18
            bit_out = carry_in;
         end
         OP_TRADE: begin
            val_out = b_in; // RULE_16
            aux_out = a_in;
         end
         OP_TRADE_LOW: begin
            val_out = {a_in[7:4], b_in[3:0]}; // RULE_16
            aux_out = {b_in[7:4], a_in[3:0]};
         end
         OP_CAND: carry_out = carry_in & bit_in; // RULE_19
         OP_CANDN: carry_out = carry_in & ~bit_in; // RULE_19
         OP_COR: carry_out = carry_in | bit_in; // RULE_19
         OP_CORN: carry_out = carry_in | ~bit_in; // RULE_19
         OP_BRBC: bit_out = 1'b0; // RULE_22
         default: val_out = a_in;
      endcase
   end

endmodule

`default_nettype wire

// *** verification/lmb_decode_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module lmb_decode_asserts import lmb_pkg::*; (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic req_valid_in,
   input wire lmb_req_t req_in,
   input wire logic ready_out,
   input wire logic done_out,
   input wire lmb_res_t res_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   wire logic take = req_valid_in && ready_out;
   ////////////////////////////////////////////////////////////
   a_done_pulse: assert property (done_out |=> !done_out)
      else $error("done held too long");
   a_busy_after_take: assert property (take |=> !ready_out [*4])
      else $error("ready during instruction");
   a_one_mc: assert property (take ##1 (res_out.cyc == CYC1) |->
      !done_out [*4] ##1 done_out)
      else $error("one cycle timing wrong");
   a_two_mc: assert property (take ##1 (res_out.cyc == CYC2) |->
      !done_out [*8] ##1 done_out)
      else $error("two cycle timing wrong");
   a_ready_back: assert property (done_out |=> ready_out)
      else $error("ready not back after done");
   a_res_hold: assert property (!take |=> $stable(res_out))
      else $error("result changed without accept");
   a_dp_pair: assert property (take && req_in.opcode == 8'h90 |=>
      res_out.dp_val == {$past(req_in.byte1), $past(req_in.byte2)})
      else $error("pointer load bytes wrong");
   a_xind_nowr: assert property (res_out.unsupported |->
      !(res_out.main_wr || res_out.mem_wr || res_out.aux_wr))
      else $error("write on unsupported move");
   a_rel_sext: assert property (take && req_in.opcode inside {8'h40, 8'h50} |=>
      res_out.br_target == $past(req_in.pc) + 16'h2 + {{8{$past(req_in.byte1[7])}},
      $past(req_in.byte1)})
      else $error("relative target wrong");
   ////////////////////////////////////////////////////////////
   c_two_mc: cover property (take ##1 res_out.cyc == CYC2);
   c_unsup: cover property (res_out.unsupported);
   c_branch: cover property (res_out.br_taken);
endmodule

`default_nettype wire

// *** verification/tb_lmb_decode_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_lmb_decode_top import lmb_pkg::*; ;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   lmb_req_t req = '0;
   logic ready;
   logic done;
   lmb_res_t res;
   int error_cnt = 0;
   int check_count = 0;
   // Opcode, byte length, machine cycles
   logic [15:0] tbl[$] = {
      16'h5811, 16'h5611, 16'h5521, 16'h5421, 16'h5221, 16'h5332,
      16'h4811, 16'h4611, 16'h4521, 16'h4421, 16'h4221, 16'h4332,
      16'h6811, 16'h6711, 16'h6521, 16'h6421, 16'h6221, 16'h6332,
      16'hc411, 16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
      16'he811, 16'he611, 16'he521, 16'h7421, 16'hf811, 16'ha822, 16'h7821,
      16'hf521, 16'h8822, 16'h8622, 16'h8532, 16'h7532,
      16'hf611, 16'ha622, 16'h7621, 16'h9032, 16'h9312, 16'h8312,
      16'he012, 16'hf012, 16'he212, 16'hf212, 16'hc811, 16'hc611, 16'hc521,
      16'hd611, 16'hc022, 16'hd022, 16'hc311, 16'hd311, 16'hb311,
      16'hc221, 16'hd221, 16'hb221, 16'ha221, 16'h9222, 16'h8222, 16'hb022,
      16'h7222, 16'ha022, 16'h4022, 16'h5022, 16'h2032, 16'h3032, 16'h1032};

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   lmb_decode_top lmb_decode_top_i (.core_clk_in(clk), .nrst_in(nrst), .req_valid_in(req_valid),
      .req_in(req), .ready_out(ready), .done_out(done), .res_out(res));
   ////////////////////////////////////////////////////////////
   task automatic final_report();
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request stays up while busy with other contents: it must be refused
   task automatic run(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2,
      output int n);
      lmb_req_t r;
      r = {opc, b1, b2, 16'h1000, 16'h2000, 8'h5a, 8'h3c, 8'hc3, 1'b1, 1'b1};
      @(posedge clk);
      req_valid <= 1'b1;
      req <= r;
      @(posedge clk);
      req <= lmb_req_t'(~r);
      n = 1;
      @(negedge clk);
      while (done !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20) begin
         error_cnt++;
         final_report();
      end
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_lengths();
      int n;
      logic [15:0] e;
      foreach (tbl[i]) begin
         e = tbl[i];
         run(e[15:8], 8'h0f, 8'h34, n);
         chk(16'(res.len), 16'(e[7:4]));
         chk(16'(res.cyc), 16'(e[3:0]));
         chk(16'(n), 16'(1 + MC_CLKS * e[3:0]));
         chk(16'(res.illegal), 16'h0);
      end
   endtask

   task automatic t_values();
      int n;
      run(8'h54, 8'h0f, 8'h00, n);
      chk(16'(res.val), 16'h000a);
      run(8'h64, 8'h0f, 8'h00, n);
      chk(16'(res.val), 16'h0055);
      run(8'hc4, 8'h00, 8'h00, n);
      chk(16'(res.val), 16'h00a5);
      run(8'hd6, 8'h00, 8'h00, n);
      chk({res.val, res.aux}, 16'h5c3a);
      chk(16'({res.aux_wr, res.main_wr}), 16'h3);
      run(8'h90, 8'h12, 8'h34, n);
      chk(res.dp_val, 16'h1234);
      chk(16'({res.dp_load, res.main_wr, res.mem_wr}), 16'h4);
      run(8'h83, 8'h00, 8'h00, n);
      chk(res.mem_addr, 16'h105b);
      run(8'he0, 8'h00, 8'h00, n);
      chk(res.mem_addr, 16'h2000);
      chk(16'({res.unsupported, res.main_wr, res.mem_wr}), 16'h2);
      run(8'he2, 8'h00, 8'h00, n);
      chk(16'({res.unsupported, res.main_wr, res.mem_wr}), 16'h4);
      run(8'h40, 8'hfe, 8'h00, n);
      chk(res.br_target, 16'h1000);
      chk(16'(res.br_taken), 16'h1);
      run(8'h50, 8'hfe, 8'h00, n);
      chk(16'(res.br_taken), 16'h0);
      run(8'h20, 8'h0b, 8'h10, n);
      chk({res.bit_byte, 5'h00, res.bit_pos}, 16'h2103);
      chk(res.br_target, 16'h1013);
      run(8'hd2, 8'hac, 8'h00, n);
      chk({res.bit_byte, 5'h00, res.bit_pos}, 16'ha804);
      chk(16'({res.bit_wr, res.bit_val}), 16'h3);
      run(8'h10, 8'h0b, 8'h02, n);
      chk(16'({res.bit_wr, res.bit_val, res.br_taken}), 16'h5);
      chk(res.br_target, 16'h1005);
      run(8'hb0, 8'h0b, 8'h00, n);
      chk(16'({res.carry_wr, res.carry}), 16'h2);
      run(8'h82, 8'h0b, 8'h00, n);
      chk(16'({res.carry_wr, res.carry}), 16'h3);
      // Arithmetic group lies outside the block
      run(8'h24, 8'h00, 8'h00, n);
      chk(16'({res.illegal, res.len}), 16'h5);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_lengths();
      t_values();
      final_report();
   end
endmodule

bind lmb_decode_top lmb_decode_asserts lmb_decode_asserts_i (.core_clk_in(core_clk_in),
   .nrst_in(nrst_in), .req_valid_in(req_valid_in), .req_in(req_in), .ready_out(ready_out),
   .done_out(done_out), .res_out(res_out));

`default_nettype wire
